/* File: adm_map.vh */
// Register offsets, field positions, reset values and limits of the ADC DC measurement block.
`ifndef ADM_MAP_VH
`define ADM_MAP_VH
`define ADM_ADDR_AGC_GAIN 8'h5D
`define ADM_ADDR_RSVD_A_LO 8'h5E
`define ADM_ADDR_RSVD_A_HI 8'h65
`define ADM_ADDR_CTRL1 8'h66
`define ADM_ADDR_CTRL2 8'h67
`define ADM_ADDR_RES_HI 8'h68
`define ADM_ADDR_RES_MID 8'h69
`define ADM_ADDR_RES_LO 8'h6A
`define ADM_ADDR_RSVD_B_LO 8'h6B
`define ADM_ADDR_RSVD_B_HI 8'h73
`define ADM_C1_ENABLE 7
`define ADM_C1_MODE_IIR 5
`define ADM_C2_FREEZE 6
`define ADM_C2_LATCH_SEL 5
`define ADM_EXP_MSB 4
`define ADM_CTRL_RESET 8'h00
`define ADM_RES_RESET 24'h000000
`define ADM_EXP_MIN 5'h01
`define ADM_EXP_MAX 5'h14
`define ADM_AVG_INFINITE 5'h00
`define ADM_GAIN_MIN 8'hE8
`define ADM_GAIN_MAX 8'h77
`endif

/* File: adm_dc_measure.v */
// ADC DC measurement unit with automatic gain loop gain readback and byte register port.
`include "adm_map.vh"
module adm_dc_measure #(
	parameter SAMPLE_W = 24
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_sample_valid,
	input wire [SAMPLE_W-1:0] i_sample,
	input wire [7:0] i_automatic_gain_loop_gain,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	output reg [7:0] o_reg_rdata,
	output wire o_meas_enabled,
	output wire o_result_update
);
	localparam ACC_W = SAMPLE_W + 21;
	localparam CNT_W = 21;
	localparam RES_BYTES = 3;
	localparam [1:0] MODE_OFF = 2'b00;
	localparam [1:0] MODE_SINC = 2'b01;
	localparam [1:0] MODE_IIR = 2'b10;
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
	localparam [ACC_W-1:0] ACC_ZERO = {ACC_W{1'b0}};

	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [7:0] rdata_d;

	reg [23:0] result_q;
	reg [23:0] result_d;
	reg result_upd_d;

	reg signed [ACC_W-1:0] acc_q;
	reg signed [ACC_W-1:0] acc_d;
	reg [CNT_W-1:0] samp_cnt_q;
	reg [CNT_W-1:0] samp_cnt_d;
	reg [CNT_W-1:0] tick_cnt_q;
	reg [CNT_W-1:0] tick_cnt_d;
	reg [1:0] mode_sel;

	wire enable;
	wire mode_iir;
	wire freeze;
	wire latch_sel;
	wire [4:0] exp_code;
	wire [4:0] avg_code;
	wire [4:0] exp_eff;
	wire wr_ctrl1;
	wire wr_ctrl2;

	wire [CNT_W-1:0] block_last;
	wire [CNT_W-1:0] avg_last;
	wire block_end;
	wire period_end;

	wire signed [ACC_W-1:0] sample_ext;
	wire signed [ACC_W-1:0] sinc_sum;
	wire signed [ACC_W-1:0] sinc_shift;
	wire signed [ACC_W-1:0] iir_shift;
	wire signed [ACC_W-1:0] iir_next;
	wire [23:0] sinc_out;
	wire [23:0] iir_out;
	wire [7:0] res_byte [0:RES_BYTES-1];

	// Clamps reserved codes into the valid range so shifts stay bounded.
	function [4:0] adm_clamp_exp;
		input [4:0] code;
		begin
			if (code < `ADM_EXP_MIN) begin
				adm_clamp_exp = `ADM_EXP_MIN;
			end else if (code > `ADM_EXP_MAX) begin
				adm_clamp_exp = `ADM_EXP_MAX;
			end else begin
				adm_clamp_exp = code;
			end
		end
	endfunction

	// Decodes one register location; both write strobes share it.
	function adm_addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			adm_addr_hit = (addr == target);
		end
	endfunction

	// Gives the last index of a window of 2^code clocks or samples.
	function [CNT_W-1:0] adm_last_index;
		input [4:0] code;
		begin
			adm_last_index = (CNT_ONE << code) - CNT_ONE;
		end
	endfunction

	assign enable = ctrl1_q[`ADM_C1_ENABLE];
	assign mode_iir = ctrl1_q[`ADM_C1_MODE_IIR];
	assign freeze = ctrl2_q[`ADM_C2_FREEZE];
	assign latch_sel = ctrl2_q[`ADM_C2_LATCH_SEL];
	assign exp_code = ctrl1_q[`ADM_EXP_MSB:0];
	assign avg_code = ctrl2_q[`ADM_EXP_MSB:0];
	assign exp_eff = adm_clamp_exp(exp_code);
	assign wr_ctrl1 = i_reg_wr && adm_addr_hit(i_reg_addr, `ADM_ADDR_CTRL1);
	assign wr_ctrl2 = i_reg_wr && adm_addr_hit(i_reg_addr, `ADM_ADDR_CTRL2);

	assign block_last = adm_last_index(exp_eff);
	assign avg_last = adm_last_index(avg_code);
	// Samples arrive at fs, so the block counter measures time in sample periods.
	assign block_end = (samp_cnt_q >= block_last);
	// Greater-or-equal lets a shortened period restart at once after a rewrite.
	assign period_end = (avg_code != `ADM_AVG_INFINITE) && (tick_cnt_q >= avg_last);

	assign sample_ext = {{(ACC_W-SAMPLE_W){i_sample[SAMPLE_W-1]}}, i_sample};
	assign sinc_sum = acc_q + sample_ext;
	assign sinc_shift = sinc_sum >>> exp_eff;
	assign sinc_out = sinc_shift[23:0];
	assign iir_shift = acc_q >>> exp_eff;
	assign iir_next = acc_q + sample_ext - iir_shift;
	assign iir_out = iir_shift[23:0];
	assign o_meas_enabled = enable;
	assign o_result_update = result_upd_d;

	// Splits the result into the three read-only byte registers, high byte first.
	genvar g;
	generate
		for (g = 0; g < RES_BYTES; g = g + 1) begin : g_res_byte
			assign res_byte[g] = result_q[23-8*g -: 8];
		end
	endgenerate

	always @* begin
		case ({enable, mode_iir})
			2'b10: begin
				mode_sel = MODE_SINC;
			end
			2'b11: begin
				mode_sel = MODE_IIR;
			end
			default: begin
				mode_sel = MODE_OFF;
			end
		endcase
	end

	// Sample and clock counters; each runs only in the mode that uses it.
	always @* begin
		samp_cnt_d = samp_cnt_q;
		tick_cnt_d = CNT_ZERO;
		case (mode_sel)
			MODE_SINC: begin
				if (i_sample_valid) begin
					if (block_end) begin
						samp_cnt_d = CNT_ZERO;
					end else begin
						samp_cnt_d = samp_cnt_q + CNT_ONE;
					end
				end
			end
			MODE_IIR: begin
				samp_cnt_d = CNT_ZERO;
				if (period_end) begin
					tick_cnt_d = CNT_ZERO;
				end else begin
					tick_cnt_d = tick_cnt_q + CNT_ONE;
				end
			end
			default: begin
				samp_cnt_d = CNT_ZERO;
			end
		endcase
	end

	always @* begin
		acc_d = acc_q;
		result_d = result_q;
		result_upd_d = 1'b0;
		case (mode_sel)
			MODE_SINC: begin
				if (i_sample_valid) begin
					if (block_end) begin
						acc_d = ACC_ZERO;
						result_d = sinc_out;
						result_upd_d = 1'b1;
					end else begin
						acc_d = sinc_sum;
					end
				end
			end
			MODE_IIR: begin
				// State form: acc holds y * 2^D, so y += (x - y) / 2^D.
				if (i_sample_valid) begin
					acc_d = iir_next;
				end
				if (!latch_sel) begin
					result_d = iir_out;
					result_upd_d = 1'b1;
				end else if (period_end) begin
					result_d = iir_out;
					result_upd_d = 1'b1;
					acc_d = ACC_ZERO;
				end
			end
			default: begin
				// Disabled: the accumulator clears but the last result stays readable.
				acc_d = ACC_ZERO;
			end
		endcase
		if (freeze) begin
			result_d = result_q;
			result_upd_d = 1'b0;
		end
	end

	// Unmapped and reserved addresses read as zero.
	always @* begin
		case (i_reg_addr)
			`ADM_ADDR_AGC_GAIN: begin
				rdata_d = i_automatic_gain_loop_gain;
			end
			`ADM_ADDR_CTRL1: begin
				rdata_d = ctrl1_q;
			end
			`ADM_ADDR_CTRL2: begin
				rdata_d = ctrl2_q;
			end
			`ADM_ADDR_RES_HI: begin
				rdata_d = res_byte[0];
			end
			`ADM_ADDR_RES_MID: begin
				rdata_d = res_byte[1];
			end
			`ADM_ADDR_RES_LO: begin
				rdata_d = res_byte[2];
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Reserved control bits are stored as written so software reads them back.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl1_q <= `ADM_CTRL_RESET;
			ctrl2_q <= `ADM_CTRL_RESET;
		end else begin
			if (wr_ctrl1) begin
				ctrl1_q <= i_reg_wdata;
			end
			if (wr_ctrl2) begin
				ctrl2_q <= i_reg_wdata;
			end
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_d;
		end
	end

	// The bytes are not snapshotted; the freeze bit gives a coherent read.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			result_q <= `ADM_RES_RESET;
			acc_q <= ACC_ZERO;
			samp_cnt_q <= CNT_ZERO;
			tick_cnt_q <= CNT_ZERO;
		end else begin
			result_q <= result_d;
			acc_q <= acc_d;
			samp_cnt_q <= samp_cnt_d;
			tick_cnt_q <= tick_cnt_d;
		end
	end

endmodule

/* File: adm_dc_measure_asserts.sv */
// Checker for the register port and result updates of the DC measurement block.
module adm_dc_measure_asserts (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_sample_valid,
	input wire [7:0] i_automatic_gain_loop_gain,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	input wire [7:0] o_reg_rdata,
	input wire o_meas_enabled,
	input wire o_result_update
);
	logic [7:0] c1_q;
	logic [7:0] c2_q;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c1_q <= 8'h00;
			c2_q <= 8'h00;
		end else if (i_reg_wr) begin
			if (i_reg_addr == 8'h66) c1_q <= i_reg_wdata;
			if (i_reg_addr == 8'h67) c2_q <= i_reg_wdata;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd(a);
		i_reg_rd && i_reg_addr == a;
	endsequence
	a_gain_read: assert property (s_rd(8'h5D)
		|=> o_reg_rdata == $past(i_automatic_gain_loop_gain)) else $error("bad gain read");
	a_ctrl1_read: assert property (s_rd(8'h66) |=> o_reg_rdata == $past(c1_q))
		else $error("bad ctrl1 read");
	a_ctrl2_read: assert property (s_rd(8'h67) |=> o_reg_rdata == $past(c2_q))
		else $error("bad ctrl2 read");
	a_enable_level: assert property (o_meas_enabled == c1_q[7])
		else $error("enable level wrong");
	a_off_quiet: assert property (!o_meas_enabled |-> !o_result_update)
		else $error("update while disabled");
	a_freeze_hold: assert property (c2_q[6] |-> !o_result_update)
		else $error("update while frozen");
	a_sinc_sample: assert property (!c1_q[5] && o_result_update |-> i_sample_valid)
		else $error("sinc update without sample");
	a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved");
endmodule

/* File: adm_dc_measure_bench.sv */
// Testbench for the DC measurement block.
module adm_dc_measure_bench;
timeunit 1ns;
timeprecision 1ns;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t: %h vs %h", $time, a, e); end end
	logic i_clk = 0;
	logic i_rst_n = 0;
	logic vld = 0;
	logic wr = 0;
	logic rd = 0;
	logic [23:0] smp = 24'h000000;
	logic [7:0] gain = 8'hE8;
	logic [7:0] adr = 8'h00;
	logic [7:0] wd = 8'h00;
	wire [7:0] rdata;
	wire en;
	wire upd;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	always #5 i_clk = ~i_clk;
	adm_dc_measure DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sample_valid(vld), .i_sample(smp),
		.i_automatic_gain_loop_gain(gain), .i_reg_addr(adr), .i_reg_wr(wr), .i_reg_wdata(wd),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .o_meas_enabled(en), .o_result_update(upd));
	task automatic step;
		@(posedge i_clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		step;
		adr = a;
		wd = d;
		wr = 1;
		step;
		wr = 0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		step;
		adr = a;
		rd = 1;
		step;
		rd = 0;
		`CHK(rdata, e)
	endtask
	task automatic res(input logic [23:0] e);
		rreg(8'h68, e[23:16]);
		rreg(8'h69, e[15:8]);
		rreg(8'h6A, e[7:0]);
	endtask
	task automatic feed(input logic [23:0] v, input logic u);
		for (int i = 0; i < 8; i++) begin
			step;
			smp = v;
			vld = 1;
			#1;
			if (i == 7) `CHK(upd, u)
			step;
			vld = 0;
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge i_clk);
		#1 i_rst_n = 1;
		res(24'h000000);
		rreg(8'h66, 8'h00);
		rreg(8'h5D, 8'hE8);
		gain = 8'h77;
		rreg(8'h5D, 8'h77);
		rreg(8'h80, 8'h00);
		$display("test reset and readback done");
		wreg(8'h66, 8'h83);
		`CHK(en, 1'h1)
		rreg(8'h66, 8'h83);
		feed(24'hFFFFF0, 1'b1);
		res(24'hFFFFF0);
		$display("test sinc average done");
		wreg(8'h67, 8'h40);
		rreg(8'h67, 8'h40);
		feed(24'h000100, 1'b0);
		res(24'hFFFFF0);
		wreg(8'h67, 8'h00);
		feed(24'h000100, 1'b1);
		res(24'h000100);
		$display("test freeze done");
		wreg(8'h66, 8'h03);
		`CHK(en, 1'h0)
		res(24'h000100);
		$display("test disable done");
		wreg(8'h66, 8'hA1);
		feed(24'h000100, 1'b1);
		res(24'h0000FF);
		wreg(8'h67, 8'h22);
		repeat (8) step;
		res(24'h000000);
		$display("test iir done");
		step;
		i_rst_n = 0;
		step;
		i_rst_n = 1;
		res(24'h000000);
		rreg(8'h66, 8'h00);
		$display("test reset again done");
		close_out;
	end
endmodule
bind adm_dc_measure adm_dc_measure_asserts u_chk (.*);
